// *** design/ddc_decim_chain.sv ***
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// ============================================================================
// One half-band stage for one real data path
module hb_decim_stage #(
  parameter int W     = 16,
  parameter int NT    = 11,
  parameter int CW    = 18,
  parameter int SHIFT = 17,
  parameter logic [((NT+1)/2)*CW-1:0] COEF = '0
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Mode
  input  wire logic                bypass,
  input  wire logic                decim_en,
  // Sample in
  input  wire logic signed [W-1:0] in_data,
  input  wire logic                in_valid,
  // Sample out
  output logic signed [W-1:0]      out_data,
  output logic                     out_valid
);
  localparam int HN = (NT + 1) / 2;
  localparam int AW = W + CW + 7;

  logic signed [W-1:0]  hist_r [NT];
  logic                 phase_r;
  logic                 fire_r;
  logic signed [AW-1:0] acc;
  logic signed [AW-1:0] rounded;
  logic signed [W-1:0]  sat_out;

  // ==========================================================================
  // Symmetric multiply-accumulate over folded tap pairs
  always_comb begin
    acc = '0;
    for (int k = 0; k < HN - 1; k++) begin
      acc = acc + AW'((AW'(hist_r[k]) + AW'(hist_r[NT-1-k]))
                      * AW'(signed'(COEF[k*CW +: CW])));
    end
    acc = acc + AW'(hist_r[HN-1]) * AW'(signed'(COEF[(HN-1)*CW +: CW]));
  end

  // Round to nearest, drop the coefficient scale, then clamp
  assign rounded = (acc + (AW'(1) <<< (SHIFT - 1))) >>> SHIFT;
  assign sat_out = (rounded > AW'((2**(W-1)) - 1)) ? W'((2**(W-1)) - 1) :
                   (rounded < -AW'(2**(W-1)))      ? W'(-(2**(W-1)))    :
                   W'(rounded);

  // ==========================================================================
  // Sample history, decimation phase and output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NT; k++) hist_r[k] <= '0;
      phase_r   <= 1'b0;
      fire_r    <= 1'b0;
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      fire_r <= 1'b0;
      if (in_valid && !bypass) begin
        hist_r[0] <= in_data;
        for (int k = 1; k < NT; k++) hist_r[k] <= hist_r[k-1];
        phase_r <= ~phase_r;
        fire_r  <= phase_r || !decim_en;
      end
      if (bypass) begin
        out_data  <= in_data;
        out_valid <= in_valid;
      end else begin
        out_valid <= fire_r;
        if (fire_r) out_data <= sat_out;
      end
    end
  end
endmodule // hb_decim_stage

module ddc_decim_chain #(
  parameter int                 W          = 16,
  parameter int                 NCH        = 2,
  parameter logic [6*18-1:0]    FIRST_COEF = {18'sd65536, 18'sd37069, 18'sd0,
                                              -18'sd4915, 18'sd0, 18'sd614},
  parameter logic [6*18-1:0]    SECOND_COEF = {18'sd65536, 18'sd37069, 18'sd0,
                                               -18'sd4915, 18'sd0, 18'sd614}
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [11:0]              addr,
  input  wire logic [7:0]               wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output wire logic [7:0]               rdata,
  // Samples from the channel mixers
  input  wire logic [NCH-1:0][W-1:0]    in_i,
  input  wire logic [NCH-1:0][W-1:0]    in_q,
  input  wire logic [NCH-1:0]           in_valid,
  // Mixer mode per channel
  output wire logic [NCH-1:0]           input_complex,
  // Samples to the output framer
  output wire logic [NCH-1:0][W-1:0]    out_i,
  output wire logic [NCH-1:0][W-1:0]    out_q,
  output wire logic [NCH-1:0]           out_valid
);
  localparam int XW = W + 2;

  logic [7:0] rdata_r;
  logic [7:0] ctrl_r [NCH];
  logic [7:0] rd_mux;

  function automatic logic [W-1:0] clamp(input logic signed [XW-1:0] v);
    if (v > XW'((2**(W-1)) - 1))  return W'((2**(W-1)) - 1);
    else if (v < -XW'(2**(W-1)))  return W'(-(2**(W-1)));
    else                          return W'(v);
  endfunction

  function automatic logic [11:0] ch_addr(input int c);
    return (c == 0) ? ddc_decim_pkg::CTRL_CH0_ADDR : ddc_decim_pkg::CTRL_CH1_ADDR;
  endfunction

  // ==========================================================================
  // Register read: data stands the cycle after the read strobe; unmapped reads 0
  always_comb begin
    rd_mux = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (addr == ch_addr(c)) rd_mux = ctrl_r[c];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata_r <= 8'h00;
    else     rdata_r <= rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_r;

  // ==========================================================================
  // Per-channel control, filter chain, complex-to-real and gain
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [1:0]          dec;
    logic                real_out;
    logic                gain6;
    logic                first_on;
    logic                second_on;
    logic                third_on;
    logic signed [W-1:0] sd [2][5];
    logic                sv [2][5];
    logic [1:0]          rot_r;
    logic signed [W-1:0] mix_i;
    logic signed [W-1:0] mix_q;
    logic [W-1:0]        oi_r;
    logic [W-1:0]        oq_r;
    logic                ov_r;
    logic                cin_r;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ctrl_r[c] <= ddc_decim_pkg::CTRL_RESET;
      end else if (wr && addr == ch_addr(c)) begin
        ctrl_r[c] <= wdata;
      end
    end

    assign dec       = ctrl_r[c][ddc_decim_pkg::DEC_MSB:ddc_decim_pkg::DEC_LSB];
    assign real_out  = ctrl_r[c][ddc_decim_pkg::REAL_OUT_BIT];
    assign gain6     = ctrl_r[c][ddc_decim_pkg::GAIN_BIT];
    assign first_on  = (dec == ddc_decim_pkg::DEC_ALL);
    assign second_on = (dec == ddc_decim_pkg::DEC_ALL) ||
                       (dec == ddc_decim_pkg::DEC_SECOND_UP);
    assign third_on  = (dec != ddc_decim_pkg::DEC_FINAL_ONLY);

    // Path 0 is in-phase, path 1 is quadrature; both share one stage order
    for (genvar p = 0; p < 2; p++) begin : g_path
      assign sd[p][0] = (p == 0) ? in_i[c] : in_q[c];
      assign sv[p][0] = in_valid[c];

      hb_decim_stage #(
        .W     (W),
        .NT    (ddc_decim_pkg::SHORT_TAPS),
        .CW    (ddc_decim_pkg::SHORT_CW),
        .SHIFT (ddc_decim_pkg::SHORT_SHIFT),
        .COEF  (FIRST_COEF)
      ) u_first_decim_stage (
        .clk       (clk),
        .rst       (rst),
        .bypass    (!first_on),
        .decim_en  (1'b1),
        .in_data   (sd[p][0]),
        .in_valid  (sv[p][0]),
        .out_data  (sd[p][1]),
        .out_valid (sv[p][1])
      );

      hb_decim_stage #(
        .W     (W),
        .NT    (ddc_decim_pkg::SHORT_TAPS),
        .CW    (ddc_decim_pkg::SHORT_CW),
        .SHIFT (ddc_decim_pkg::SHORT_SHIFT),
        .COEF  (SECOND_COEF)
      ) u_second_decim_stage (
        .clk       (clk),
        .rst       (rst),
        .bypass    (!second_on),
        .decim_en  (1'b1),
        .in_data   (sd[p][1]),
        .in_valid  (sv[p][1]),
        .out_data  (sd[p][2]),
        .out_valid (sv[p][2])
      );

      hb_decim_stage #(
        .W     (W),
        .NT    (ddc_decim_pkg::THIRD_TAPS),
        .CW    (ddc_decim_pkg::THIRD_CW),
        .SHIFT (ddc_decim_pkg::THIRD_SHIFT),
        .COEF  (ddc_decim_pkg::THIRD_COEF)
      ) u_third_decim_stage (
        .clk       (clk),
        .rst       (rst),
        .bypass    (!third_on),
        .decim_en  (1'b1),
        .in_data   (sd[p][2]),
        .in_valid  (sv[p][2]),
        .out_data  (sd[p][3]),
        .out_valid (sv[p][3])
      );

      hb_decim_stage #(
        .W     (W),
        .NT    (ddc_decim_pkg::FINAL_TAPS),
        .CW    (ddc_decim_pkg::FINAL_CW),
        .SHIFT (ddc_decim_pkg::FINAL_SHIFT),
        .COEF  (ddc_decim_pkg::FINAL_COEF)
      ) u_final_decim_stage (
        .clk       (clk),
        .rst       (rst),
        .bypass    (1'b0),
        .decim_en  (!real_out),
        .in_data   (sd[p][3]),
        .in_valid  (sv[p][3]),
        .out_data  (sd[p][4]),
        .out_valid (sv[p][4])
      );
    end

    // fs/4 upconversion: multiply by j^n, keep only the in-phase result
    always_comb begin
      mix_i = sd[0][4];
      mix_q = sd[1][4];
      if (real_out) begin
        mix_q = '0;
        unique case (rot_r)
          2'h0: mix_i = sd[0][4];
          2'h1: mix_i = W'(clamp(-XW'(sd[1][4])));
          2'h2: mix_i = W'(clamp(-XW'(sd[0][4])));
          2'h3: mix_i = sd[1][4];
        endcase
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rot_r <= 2'h0;
        oi_r  <= '0;
        oq_r  <= '0;
        ov_r  <= 1'b0;
        cin_r <= 1'b0;
      end else begin
        cin_r <= ctrl_r[c][ddc_decim_pkg::CPLX_IN_BIT];
        ov_r  <= sv[0][4];
        if (!real_out) rot_r <= 2'h0;
        else if (sv[0][4]) rot_r <= rot_r + 2'h1;
        if (sv[0][4]) begin
          oi_r <= gain6 ? clamp(XW'(mix_i) <<< 1) : mix_i;
          oq_r <= gain6 ? clamp(XW'(mix_q) <<< 1) : mix_q;
        end
      end
    end

    assign out_i[c]         = oi_r;
    assign out_q[c]         = oq_r;
    assign out_valid[c]     = ov_r;
    assign input_complex[c] = cin_r;
  end
endmodule // ddc_decim_chain

// *** include/ddc_decim_pkg.sv ***
package ddc_decim_pkg;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W          = 12;
  localparam int          REG_W           = 8;
  localparam logic [11:0] CTRL_CH0_ADDR   = 12'h310;
  localparam logic [11:0] CTRL_CH1_ADDR   = 12'h330;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // ==========================================================================
  // Control register fields
  localparam int          DEC_LSB         = 0;
  localparam int          DEC_MSB         = 1;
  localparam int          REAL_OUT_BIT    = 3;
  localparam int          GAIN_BIT        = 6;
  localparam int          CPLX_IN_BIT     = 7;

  // Decimation field codes: which optional stages run in front of the final one
  localparam logic [1:0]  DEC_FINAL_ONLY  = 2'h3;
  localparam logic [1:0]  DEC_THIRD_UP    = 2'h0;
  localparam logic [1:0]  DEC_SECOND_UP   = 2'h1;
  localparam logic [1:0]  DEC_ALL         = 2'h2;

  // ==========================================================================
  // First and second stages (11 taps, outer pair first, centre last)
  localparam int          SHORT_TAPS      = 11;
  localparam int          SHORT_CW        = 18;
  localparam int          SHORT_SHIFT     = 17;

  // ==========================================================================
  // Third stage (19 taps, 19-bit coefficients, centre 131072 = one half)
  localparam int          THIRD_TAPS      = 19;
  localparam int          THIRD_CW        = 19;
  localparam int          THIRD_SHIFT     = 18;
  localparam logic [10*19-1:0] THIRD_COEF = {
    19'sd131072, 19'sd80160, 19'sd0, -19'sd19272, 19'sd0,
    19'sd5814, 19'sd0, -19'sd1328, 19'sd0, 19'sd161};

  // ==========================================================================
  // Final stage (55 taps, 21-bit coefficients, centre 524288 = one half)
  localparam int          FINAL_TAPS      = 55;
  localparam int          FINAL_CW        = 21;
  localparam int          FINAL_SHIFT     = 20;
  localparam logic [28*21-1:0] FINAL_COEF = {
    21'sd524288, 21'sd331792, 21'sd0, -21'sd105442, 21'sd0, 21'sd57468, 21'sd0,
    -21'sd35476, 21'sd0, 21'sd22640, 21'sd0, -21'sd14383, 21'sd0, 21'sd8903,
    21'sd0, -21'sd5284, 21'sd0, 21'sd2964, 21'sd0, -21'sd1544, 21'sd0,
    21'sd730, 21'sd0, -21'sd302, 21'sd0, 21'sd102, 21'sd0, -21'sd24};

endpackage

// *** tb/ddc_decim_chk.sv ***
`timescale 1ns/1ps

// ====================================
// Port checker for the decimation chain
module ddc_decim_chk #(
  parameter int W   = 16,
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [11:0]           addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  input  wire logic [7:0]            rdata,
  // Sample streams
  input  wire logic [NCH-1:0][W-1:0] in_i,
  input  wire logic [NCH-1:0][W-1:0] in_q,
  input  wire logic [NCH-1:0]        in_valid,
  input  wire logic [NCH-1:0]        input_complex,
  input  wire logic [NCH-1:0][W-1:0] out_i,
  input  wire logic [NCH-1:0][W-1:0] out_q,
  input  wire logic [NCH-1:0]        out_valid
);
  wire logic       sel0;
  wire logic       sel1;
  logic      [7:0] ctrl0_r;

  assign sel0 = (addr == ddc_decim_pkg::CTRL_CH0_ADDR);
  assign sel1 = (addr == ddc_decim_pkg::CTRL_CH1_ADDR);

  // Shadow of the channel 0 control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl0_r <= ddc_decim_pkg::CTRL_RESET;
    else if (wr && sel0) ctrl0_r <= wdata;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  readback_a: assert property (rd && sel0 |=> rdata == ctrl0_r)
    else $error("control readback wrong");
  unmapped_rd_a: assert property (rd && !sel0 && !sel1 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Input type is re-registered from the control register, so it lags the write by two edges
  cplx_follow_a: assert property (wr && sel0 |=> ##1 input_complex[0] == $past(ctrl0_r[7]))
    else $error("input type not taken");
  chan_indep_a: assert property (wr && sel0 |=> ##1 $stable(input_complex[1]))
    else $error("channel 1 disturbed");
  real_q_zero_a: assert property (out_valid[0] && ctrl0_r[3] |-> out_q[0] == '0)
    else $error("quadrature kept in real mode");
  // Three bypass registers, the final stage and the output register lie behind the input
  final_lat_a: assert property (out_valid[0] && ctrl0_r[1:0] == 2'h3 && !ctrl0_r[3]
    |-> $past(in_valid[0], 6)) else $error("final stage timing wrong");
  dec_gap_a: assert property (out_valid[0] && !ctrl0_r[3] |=> !out_valid[0])
    else $error("decimating stage output twice");

  cover property (out_valid[0] && ctrl0_r[3]);
  cover property (out_valid[0] && ctrl0_r[6]);
  cover property (rd && sel1);
endmodule // ddc_decim_chk

bind ddc_decim_chain ddc_decim_chk #(.W(W), .NCH(NCH)) chk_i (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .in_i(in_i), .in_q(in_q), .in_valid(in_valid), .input_complex(input_complex),
  .out_i(out_i), .out_q(out_q), .out_valid(out_valid));

// *** tb/mixer_model.sv ***
`timescale 1ns/1ps

// ====================================
// Upstream mixer: one sample per cycle to every channel
module mixer_model #(
  parameter int W   = 16,
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  start,
  input  wire logic [15:0]           n_samp,
  input  wire logic signed [W-1:0]   amp,
  input  wire logic                  dc,
  input  wire logic [15:0]           pidx,
  // Samples
  output logic [NCH-1:0][W-1:0]      in_i,
  output logic [NCH-1:0][W-1:0]      in_q,
  output logic [NCH-1:0]             in_valid,
  output logic                       busy
);
  logic        [15:0]  k_r;
  logic signed [W-1:0] v;

  assign v = (dc || k_r == pidx) ? amp : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      k_r <= '0;
      busy <= 1'b0;
      in_valid <= '0;
      in_i <= '0;
      in_q <= '1;
    end else begin
      in_valid <= {NCH{busy}};
      if (busy) begin
        in_i <= {NCH{v}};
        in_q <= {NCH{-v}};
        k_r <= k_r + 16'h1;
        busy <= (k_r + 16'h1 != n_samp);
      end else begin
        // Idle data toggles so stale values are never mistaken for samples
        in_i <= ~in_i;
        in_q <= ~in_q;
        busy <= start;
        k_r <= '0;
      end
    end
  end
endmodule // mixer_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got); end end

module testbench;
  localparam logic [11:0] CH0 = ddc_decim_pkg::CTRL_CH0_ADDR;
  localparam logic [11:0] CH1 = ddc_decim_pkg::CTRL_CH1_ADDR;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [11:0]              addr = '0;
  logic [7:0]               wdata = '0;
  logic                     wr = 1'b0;
  logic                     rd = 1'b0;
  logic                     start = 1'b0;
  logic                     dc = 1'b1;
  logic [15:0]              n_samp = '0;
  logic [15:0]              pidx = '0;
  logic signed [15:0]       amp = '0;
  logic [7:0]               rdata, rv;
  logic [1:0][15:0]         in_i, in_q, out_i, out_q;
  logic [1:0]               in_valid, out_valid, input_complex;
  logic                     busy;
  logic signed [15:0]       i0, q0, i1, q1, hi, lo;
  int                       error_cnt = 0;
  int                       tests_run = 0;
  int                       cyc = 0;
  int                       cnt0, cnt1;

  ddc_decim_chain DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .in_i(in_i), .in_q(in_q), .in_valid(in_valid),
    .input_complex(input_complex), .out_i(out_i), .out_q(out_q), .out_valid(out_valid));
  mixer_model src (.clk(clk), .rst(rst), .start(start), .n_samp(n_samp), .amp(amp),
    .dc(dc), .pidx(pidx), .in_i(in_i), .in_q(in_q), .in_valid(in_valid), .busy(busy));

  always #50 clk = ~clk;

  // ====================================
  // Watchdog and output monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
    if (out_valid[0] === 1'b1) begin
      cnt0++;
      i0 = out_i[0];
      q0 = out_q[0];
      if (i0 > hi) hi = i0;
      if (i0 < lo) lo = i0;
    end
    if (out_valid[1] === 1'b1) begin
      cnt1++;
      i1 = out_i[1];
      q1 = out_q[1];
    end
  end

  // ====================================
  // Bus and stream tasks
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cnt0 = 0;
    cnt1 = 0;
    hi = 16'sh8000;
    lo = 16'sh7FFF;
  endtask

  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    rv = rdata;
  endtask

  task run(input logic [15:0] n, input logic signed [15:0] a, input logic d,
           input logic [15:0] p);
    @(posedge clk);
    start <= 1'b1;
    n_samp <= n;
    amp <= a;
    dc <= d;
    pidx <= p;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    repeat (400) @(posedge clk);
  endtask

  // ====================================
  // Scenarios
  task t_regs;
    do_reset();
    rd_reg(CH0);
    `CHK("ctrl0 reset", ddc_decim_pkg::CTRL_RESET, rv)
    wr_reg(CH0, 8'h8A);
    wr_reg(CH1, 8'h41);
    wr_reg(12'h311, 8'hFF);
    rd_reg(CH0);
    `CHK("ctrl0", 8'h8A, rv)
    rd_reg(CH1);
    `CHK("ctrl1", 8'h41, rv)
    rd_reg(12'h311);
    `CHK("unmapped", 8'h00, rv)
    `CHK("input type", 2'b01, input_complex)
    $display("test regs done");
  endtask

  task t_mode(input logic [7:0] c, input int div, input logic signed [15:0] a,
              input logic signed [15:0] ei, input logic signed [15:0] eq);
    do_reset();
    wr_reg(CH0, c);
    run(16'd1024, a, 1'b1, 16'd0);
    `CHK("ch0 rate", 1024 / div, cnt0)
    `CHK("ch0 i", ei, i0)
    `CHK("ch0 q", eq, q0)
    `CHK("ch1 rate", 256, cnt1)
    `CHK("ch1 i", a, i1)
    `CHK("ch1 q", -a, q1)
    $display("test mode %0h done", c);
  endtask

  task t_modes;
    t_mode(8'h03, 2, 16'sd1000, 16'sd1000, -16'sd1000);
    t_mode(8'h00, 4, 16'sd1000, 16'sd1000, -16'sd1000);
    t_mode(8'h01, 8, 16'sd1000, 16'sd1000, -16'sd1000);
    t_mode(8'h02, 16, 16'sd1000, 16'sd1000, -16'sd1000);
    // Real output: output counts are multiples of four, so the last one is rotation Q
    t_mode(8'h0B, 1, 16'sd1000, -16'sd1000, 16'sd0);
    t_mode(8'h08, 2, 16'sd1000, -16'sd1000, 16'sd0);
    t_mode(8'h4A, 8, 16'sd1000, -16'sd2000, 16'sd0);
    t_mode(8'hC3, 2, 16'sd1000, 16'sd2000, -16'sd2000);
    t_mode(8'h43, 2, 16'sd20000, 16'sd32767, 16'sh8000);
  endtask

  task t_impulse;
    logic signed [15:0] h [2];
    logic signed [15:0] l [2];
    for (int p = 0; p < 2; p++) begin
      do_reset();
      wr_reg(CH0, 8'h03);
      run(16'd128, 16'sd32767, 1'b0, 16'(p));
      h[p] = hi;
      l[p] = lo;
    end
    `CHK("centre", 16'sd16384, (h[0] > h[1]) ? h[0] : h[1])
    `CHK("inner", 16'sd10368, (h[0] < h[1]) ? h[0] : h[1])
    `CHK("low", -16'sd3295, (l[0] < l[1]) ? l[0] : l[1])
    $display("test impulse done");
  endtask

  task close_out;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_regs();
    t_modes();
    t_impulse();
    close_out();
  end
endmodule // testbench
